// >>> verilog/vmx_regs.sv
// Purpose: A16 device registers and A24 relay registers of the matrix module
// Assumes: Bus strobes are one-cycle pulses synchronous to mclk
// Notes:   One ack pulse per accepted access, one cycle after the strobe
//
// How it works
// R1: Device registers are 16-bit in A16; relay registers sit separately in A24.
// R2: Status/control at 04h, offset at 06h, control at 3Eh; 08h-3Ch unused.
// R3: Offset register readable by all; written contents taken as manager configuration.
// R4: Every write replaces all sixteen bits; host does read-modify-write.
// R5: Setting the device reset bit returns relay words, coil drive and readback control to power-up state; other registers keep values.
// R6: While device reset bit is set, all relays stay open.
// R7: Device reset is bit 0 of status/control.
// R8: A16 window decoded at logical address times 40h plus C000h.
// R9: Offset zero reads the identification register.
// R10: Nonprivileged 16-bit word accesses accepted in A16.
// R11: Relay registers at 8000h above A24 base; 16- or 32-bit access.
// R12: Control bit 1 selects coil or data readback; cleared by module reset.
`timescale 1ns/1ps
module vmx_regs
   import vmx_pkg::*;
#(
   parameter logic [15:0] ID_VALUE   = 16'h0F00,  // Arbitrary identification value
   parameter logic [15:0] DEV_TYPE   = 16'h0000,  // Arbitrary device type value
   parameter int          RELAY_BITS = 32
)(
   input  wire logic                  mclk,            // System clock
   input  wire logic                  reset,           // Power-up reset, active high
   input  wire logic [7:0]            logical_addr,    // Module logical address
   input  wire logic                  a16_strobe,      // A16 access pulse
   input  wire logic [5:0]            a16_am,          // A16 address modifier
   input  wire logic [15:0]           a16_addr,        // A16 byte address
   input  wire logic                  a16_write,       // 1 write, 0 read
   input  wire logic [15:0]           a16_wdata,       // A16 write word
   output logic      [15:0]           a16_rdata,       // A16 read word
   output logic                       a16_ack,         // A16 access done
   input  wire logic                  a24_strobe,      // A24 access pulse
   input  wire logic [5:0]            a24_am,          // A24 address modifier
   input  wire logic [23:0]           a24_addr,        // A24 byte address
   input  wire logic                  a24_long,        // 1: 32-bit access
   input  wire logic                  a24_write,       // 1 write, 0 read
   input  wire logic [31:0]           a24_wdata,       // A24 write data
   output logic      [31:0]           a24_rdata,       // A24 read data
   output logic                       a24_ack,         // A24 access done
   input  wire logic [RELAY_BITS-1:0] coil_state,      // Coil feedback
   output logic      [RELAY_BITS-1:0] coil_drive,      // Coil drive, all open in reset
   output logic                       dev_reset_active // Device reset bit mirror
);
   localparam int HALF = RELAY_BITS / 2;

   generate
      if (RELAY_BITS != 32) begin : g_bad_width
         $error("vmx_regs: RELAY_BITS must be 32");
      end
      if (HALF != 16) begin : g_bad_half
         $error("vmx_regs: each relay word must fill one 16-bit register");
      end
   endgenerate

   logic [15:0] stat_ctrl_r;
   logic [15:0] a24_offset_r;
   logic [15:0] relay_ctrl_r;
   logic [15:0] win_base;
   logic        a16_hit;
   logic        a24_hit;
   logic        a24_lo_sel;
   logic        a24_hi_sel;
   logic        mod_rst;
   logic [5:0]  reg_off;
   logic [15:0] a16_rd_nxt;
   logic [HALF-1:0] rd_lo;
   logic [HALF-1:0] rd_hi;
   logic [HALF-1:0] drv_lo;
   logic [HALF-1:0] drv_hi;
   logic [HALF-1:0] wd_hi;
   logic        wr_lo;
   logic        wr_hi;
   logic        wr_stat_ctrl;
   logic        wr_a24_offset;
   logic        wr_relay_ctrl;
   logic        a16_rd_en;
   logic        a24_rd_en;
   logic        dev_rst_bit;
   logic        read_sel_data;
   logic [31:0] a24_rd_nxt;
   logic [RELAY_BITS-1:0] coil_drive_nxt;

   // Register picked by the A16 offset
   typedef enum logic [2:0] {
      VMX_SEL_ID       = 3'b000,
      VMX_SEL_DEV_TYPE = 3'b001,
      VMX_SEL_STAT     = 3'b010,
      VMX_SEL_OFFSET   = 3'b011,
      VMX_SEL_RELAY    = 3'b100,
      VMX_SEL_UNUSED   = 3'b101
   } vmx_a16_sel_type;

   // Relay word picked by an A24 access
   typedef enum logic [1:0] {
      VMX_A24_NONE = 2'b00,
      VMX_A24_LO   = 2'b01,
      VMX_A24_HI   = 2'b10,
      VMX_A24_BOTH = 2'b11
   } vmx_a24_sel_type;

   vmx_a16_sel_type a16_sel;
   vmx_a24_sel_type a24_sel;

   // Power-up reset or the software device reset
   assign dev_rst_bit   = stat_ctrl_r[BIT_DEV_RESET];                          // R7
   assign mod_rst       = reset || dev_rst_bit;                                // R5
   assign win_base      = A16_WIN_BASE + (16'(logical_addr) << A16_LA_SHIFT);  // R8
   assign reg_off       = a16_addr[A16_LA_SHIFT-1:0];
   assign read_sel_data = relay_ctrl_r[BIT_READ_DATA];                         // R12
   assign a16_hit  = a16_strobe && (a16_am == AM_A16_NPRIV)
                     && (a16_addr[15:A16_LA_SHIFT] == win_base[15:A16_LA_SHIFT])
                     && !a16_addr[0];                              // R8 R10

   assign wr_stat_ctrl  = a16_hit && a16_write && (a16_sel == VMX_SEL_STAT);    // R4
   assign wr_a24_offset = a16_hit && a16_write && (a16_sel == VMX_SEL_OFFSET);  // R3
   assign wr_relay_ctrl = a16_hit && a16_write && (a16_sel == VMX_SEL_RELAY);   // R12
   assign a16_rd_en     = a16_hit && !a16_write;

   // Unused offsets share one code, so they read zero and ignore writes
   always_comb begin
      unique case (reg_off)
         OFF_ID: begin
            a16_sel = VMX_SEL_ID;                                       // R9
         end
         OFF_DEV_TYPE: begin
            a16_sel = VMX_SEL_DEV_TYPE;
         end
         OFF_STAT_CTRL: begin
            a16_sel = VMX_SEL_STAT;                                     // R7
         end
         OFF_A24_OFFSET: begin
            a16_sel = VMX_SEL_OFFSET;                                   // R3
         end
         OFF_RELAY_CTRL: begin
            a16_sel = VMX_SEL_RELAY;                                    // R12
         end
         default: begin
            a16_sel = VMX_SEL_UNUSED;                                   // R2
         end
      endcase
   end

   // A24 base comes from the offset register the manager programmed
   assign a24_hit    = a24_strobe && (a24_am == AM_A24_NPRIV)
                       && (a24_addr[23:A24_BASE_LSB] == a24_offset_r[15:OFFSET_BASE_LSB]); // R1 R11
   assign a24_lo_sel = a24_hit && (a24_addr[15:0] == A24_RELAY_LO);                 // R11
   assign a24_hi_sel = a24_hit && !a24_long && (a24_addr[15:0] == A24_RELAY_HI);    // R11
   assign wr_lo      = a24_lo_sel && a24_write;
   assign wr_hi      = (a24_hi_sel || (a24_lo_sel && a24_long)) && a24_write;
   assign wd_hi      = a24_long ? a24_wdata[31:16] : a24_wdata[15:0];

   // A 32-bit access at the low word covers both halves
   always_comb begin
      a24_sel = VMX_A24_NONE;
      if (a24_lo_sel && a24_long) begin
         a24_sel = VMX_A24_BOTH;                                    // R11
      end else if (a24_lo_sel) begin
         a24_sel = VMX_A24_LO;
      end else if (a24_hi_sel) begin
         a24_sel = VMX_A24_HI;
      end
   end
   assign a24_rd_en = (a24_sel != VMX_A24_NONE) && !a24_write;

   always_comb begin
      unique case (a24_sel)
         VMX_A24_BOTH: a24_rd_nxt = {rd_hi, rd_lo};                 // R11
         VMX_A24_LO:   a24_rd_nxt = 32'(rd_lo);
         VMX_A24_HI:   a24_rd_nxt = 32'(rd_hi);
         VMX_A24_NONE: a24_rd_nxt = '0;
      endcase
   end

   // Status/control keeps its own value through device reset, or it could never clear
   always_ff @(posedge mclk) begin
      if (reset) begin
         stat_ctrl_r <= STAT_CTRL_RST;
      end else if (wr_stat_ctrl) begin
         stat_ctrl_r <= a16_wdata;                                  // R4 R6 R7
      end
   end

   // Offset survives device reset so the A24 mapping stays valid
   always_ff @(posedge mclk) begin
      if (reset) begin
         a24_offset_r <= A24_OFFSET_RST;
      end else if (wr_a24_offset) begin
         a24_offset_r <= a16_wdata;                                 // R3 R4
      end
   end

   always_ff @(posedge mclk) begin
      if (mod_rst) begin
         relay_ctrl_r <= RELAY_CTRL_RST;                            // R12 R5
      end else if (wr_relay_ctrl) begin
         relay_ctrl_r <= a16_wdata;                                 // R4
      end
   end

   always_comb begin
      unique case (a16_sel)
         VMX_SEL_ID: begin
            a16_rd_nxt = ID_VALUE;                                  // R9
         end
         VMX_SEL_DEV_TYPE: begin
            a16_rd_nxt = DEV_TYPE;
         end
         VMX_SEL_STAT: begin
            a16_rd_nxt = stat_ctrl_r;
         end
         VMX_SEL_OFFSET: begin
            a16_rd_nxt = a24_offset_r;                              // R3
         end
         VMX_SEL_RELAY: begin
            a16_rd_nxt = relay_ctrl_r;
         end
         VMX_SEL_UNUSED: begin
            a16_rd_nxt = READ_ZERO;                                 // R2
         end
         default: begin
            a16_rd_nxt = READ_ZERO;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         a16_ack <= 1'b0;
      end else begin
         a16_ack <= a16_hit;                                        // R10
      end
   end

   // Read data holds until the next accepted read
   always_ff @(posedge mclk) begin
      if (reset) begin
         a16_rdata <= READ_ZERO;
      end else if (a16_rd_en) begin
         a16_rdata <= a16_rd_nxt;                                   // R2
      end
   end

   vmx_relay_word #(.WIDTH(HALF)) u_lo (
      .mclk       (mclk),
      .mod_rst    (mod_rst),
      .hold_open  (dev_rst_bit),
      .wr_en      (wr_lo),
      .wdata      (a24_wdata[HALF-1:0]),
      .read_data  (read_sel_data),
      .coil_state (coil_state[HALF-1:0]),
      .rdata      (rd_lo),
      .coil_drive (drv_lo)
   );

   vmx_relay_word #(.WIDTH(HALF)) u_hi (
      .mclk       (mclk),
      .mod_rst    (mod_rst),
      .hold_open  (dev_rst_bit),
      .wr_en      (wr_hi),
      .wdata      (wd_hi),
      .read_data  (read_sel_data),
      .coil_state (coil_state[RELAY_BITS-1:HALF]),
      .rdata      (rd_hi),
      .coil_drive (drv_hi)
   );

   // Hold-open applied again here, so pins open in the cycle the mirror rises
   assign coil_drive_nxt = dev_rst_bit ? '0 : {drv_hi, drv_lo};

   always_ff @(posedge mclk) begin
      if (reset) begin
         coil_drive <= '0;
      end else begin
         coil_drive <= coil_drive_nxt;                              // R6
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         dev_reset_active <= 1'b0;
      end else begin
         dev_reset_active <= dev_rst_bit;                           // R7
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         a24_ack <= 1'b0;
      end else begin
         a24_ack <= (a24_sel != VMX_A24_NONE);                      // R11
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         a24_rdata <= '0;
      end else if (a24_rd_en) begin
         a24_rdata <= a24_rd_nxt;                                   // R11
      end
   end
endmodule : vmx_regs

// >>> verilog/vmx_pkg.sv
// Purpose: Shared constants for the matrix module register bank
// Assumes: 16-bit A16 device registers, 32-bit relay image in A24
// Notes:   Offsets are byte offsets inside each window
package vmx_pkg;
   // A16 device register window
   localparam logic [15:0] A16_WIN_BASE   = 16'hC000;
   localparam int          A16_LA_SHIFT   = 6;          // Logical address times 0x40
   localparam logic [5:0]  OFF_ID         = 6'h00;
   localparam logic [5:0]  OFF_DEV_TYPE   = 6'h02;
   localparam logic [5:0]  OFF_STAT_CTRL  = 6'h04;
   localparam logic [5:0]  OFF_A24_OFFSET = 6'h06;
   localparam logic [5:0]  OFF_RELAY_CTRL = 6'h3E;

   // Field positions
   localparam int BIT_DEV_RESET = 0;                    // In module_status_control
   localparam int BIT_READ_DATA = 1;                    // In relay_readback_control

   // Reset values
   localparam logic [15:0] STAT_CTRL_RST  = 16'h0000;
   localparam logic [15:0] A24_OFFSET_RST = 16'h0000;
   localparam logic [15:0] RELAY_CTRL_RST = 16'h0000;
   localparam logic [15:0] RELAY_WORD_RST = 16'h0000;
   localparam logic [15:0] READ_ZERO      = 16'h0000;

   // Address modifiers: nonprivileged data access
   localparam logic [5:0]  AM_A16_NPRIV   = 6'h29;
   localparam logic [5:0]  AM_A24_NPRIV   = 6'h39;

   // A24 relay registers above the assigned base
   localparam logic [15:0] A24_RELAY_LO   = 16'h8000;   // Channels 1-16
   localparam logic [15:0] A24_RELAY_HI   = 16'h8002;   // Channels 17-32
   localparam int          A24_BASE_LSB   = 16;         // Base taken from offset[15:8]
   localparam int          OFFSET_BASE_LSB = 8;
endpackage : vmx_pkg

// >>> verilog/vmx_relay_word.sv
// Purpose: One 16-bit half of the relay image with coil drive
// Assumes: Caller supplies the module-reset term and hold-open level
// Notes:   Read data chooses coil feedback or programmed data
`timescale 1ns/1ps
module vmx_relay_word
   import vmx_pkg::*;
#(
   parameter int WIDTH = 16
)(
   input  wire logic             mclk,        // System clock
   input  wire logic             mod_rst,     // Power-up or device reset
   input  wire logic             hold_open,   // Force every coil off
   input  wire logic             wr_en,       // Write this half
   input  wire logic [WIDTH-1:0] wdata,       // Whole-word write data
   input  wire logic             read_data,   // 1: programmed data, 0: coils
   input  wire logic [WIDTH-1:0] coil_state,  // Coil feedback
   output logic      [WIDTH-1:0] rdata,       // Readback value
   output logic      [WIDTH-1:0] coil_drive   // Registered coil drive
);
   logic [WIDTH-1:0] data_r;

   always_ff @(posedge mclk) begin
      if (mod_rst) begin
         data_r <= WIDTH'(RELAY_WORD_RST);       // R5
      end else if (wr_en) begin
         data_r <= wdata;
      end
   end

   // Drive off while held, so no relay closes until the hold lifts
   always_ff @(posedge mclk) begin
      if (mod_rst || hold_open) begin
         coil_drive <= '0;                       // R6
      end else begin
         coil_drive <= data_r;
      end
   end

   always_comb begin
      rdata = read_data ? data_r : coil_state;   // R12
   end
endmodule : vmx_relay_word

// >>> verilog/placeholder_none.sv
`timescale 1ns/1ps

// >>> verif/vmx_coil_model.sv
// Purpose: Coil feedback model for the relay drive
// Assumes: Coils settle within one mclk
// Notes:   stuck_lsb mimics a failed coil 0
`timescale 1ns/1ps
module vmx_coil_model (
   input  wire logic        mclk,       // System clock
   input  wire logic        stuck_lsb,  // Fault on coil 0
   input  wire logic [31:0] coil_drive, // From the bank
   output logic      [31:0] coil_state  // Feedback
);
   always_ff @(posedge mclk) begin
      coil_state <= coil_drive ^ {31'h0, stuck_lsb};
   end
endmodule : vmx_coil_model

// >>> verif/vmx_regs_chk.sv
// Purpose: Port checks of the register bank
// Assumes: One clock, sync reset
// Notes:   Bound to every vmx_regs
`timescale 1ns/1ps
module vmx_regs_chk
   import vmx_pkg::*;
#(parameter int RELAY_BITS = 32) (
   input wire logic                  mclk,
   input wire logic                  reset,
   input wire logic [7:0]            logical_addr,
   input wire logic                  a16_strobe,
   input wire logic [5:0]            a16_am,
   input wire logic [15:0]           a16_addr,
   input wire logic                  a16_write,
   input wire logic [15:0]           a16_wdata,
   input wire logic                  a16_ack,
   input wire logic                  a24_strobe,
   input wire logic [23:0]           a24_addr,
   input wire logic                  a24_long,
   input wire logic                  a24_ack,
   input wire logic [RELAY_BITS-1:0] coil_drive,
   input wire logic                  dev_reset_active
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   logic [15:0] win;
   logic        hit;
   logic        sc_wr;
   assign win = A16_WIN_BASE + {2'b00, logical_addr, 6'h00};
   assign hit = a16_strobe && a16_am == AM_A16_NPRIV && !a16_addr[0] && a16_addr[15:6] == win[15:6];
   assign sc_wr = hit && a16_write && a16_addr[5:0] == OFF_STAT_CTRL;
   property p_ack_cause; a16_ack |-> $past(hit); endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("a16 ack without valid access");
   property p_ack_given; hit |=> a16_ack; endproperty
   a_ack_given: assert property (p_ack_given) else $error("a16 access not acked");
   property p_bad_am; a16_strobe && (a16_am != AM_A16_NPRIV || a16_addr[0]) |=> !a16_ack; endproperty
   a_bad_am: assert property (p_bad_am) else $error("refused a16 access acked");
   property p_rst_set; sc_wr && a16_wdata[BIT_DEV_RESET] |=> ##1 dev_reset_active; endproperty
   a_rst_set: assert property (p_rst_set) else $error("device reset not entered");
   property p_rst_clr; sc_wr && !a16_wdata[BIT_DEV_RESET] |=> ##1 !dev_reset_active; endproperty
   a_rst_clr: assert property (p_rst_clr) else $error("device reset not left");
   property p_open; dev_reset_active |-> coil_drive == '0; endproperty
   a_open: assert property (p_open) else $error("relay driven in device reset");
   property p_a24_ack; a24_ack |-> $past(a24_strobe); endproperty
   a_a24_ack: assert property (p_a24_ack) else $error("a24 ack without strobe");
   property p_a24_long; a24_strobe && a24_long && a24_addr[15:0] != A24_RELAY_LO |=> !a24_ack; endproperty
   a_a24_long: assert property (p_a24_long) else $error("bad long access acked");
   property p_pwr; disable iff (1'b0) $fell(reset) |-> !a16_ack && !dev_reset_active && coil_drive == '0; endproperty
   a_pwr: assert property (p_pwr) else $error("outputs not clear after reset");
   c_wr: cover property (sc_wr);
   c_dev: cover property (dev_reset_active);
   c_a24: cover property (a24_ack);
endmodule : vmx_regs_chk
bind vmx_regs vmx_regs_chk #(.RELAY_BITS(RELAY_BITS)) chk_u (.mclk, .reset, .logical_addr, .a16_strobe, .a16_am,
   .a16_addr, .a16_write, .a16_wdata, .a16_ack, .a24_strobe, .a24_addr, .a24_long, .a24_ack, .coil_drive,
   .dev_reset_active);

// >>> verif/vmx_regs_tb.sv
// Purpose: Self-checking bench of the register bank
// Assumes: Inputs change on falling mclk
// Notes:   Driver queues expectations, monitor pops on ack
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
   $display("unexpected %s exp %h got %h", nm, e, g); end end
module vmx_regs_tb;
   import vmx_pkg::*;
   localparam logic [15:0] ID_V = 16'h5A5A; // Arbitrary identification value
   localparam logic [15:0] DT_V = 16'h0A0B; // Arbitrary device type value
   logic mclk = 0, reset = 1, a16_strobe = 0, a16_write = 0, a24_strobe = 0, a24_long = 0, a24_write = 0, stuck = 0;
   logic a16_ack, a24_ack, dev_reset_active;
   logic [7:0] la = 0;
   logic [5:0] a16_am = 0, a24_am = 0;
   logic [15:0] a16_addr = 0, a16_wdata = 0, a16_rdata, base, w;
   logic [23:0] a24_addr = 0;
   logic [31:0] a24_wdata = 0, a24_rdata, coil_state, coil_drive, r;
   logic [33:0] q16[$], q24[$], t;
   int num_errors = 0, cmp_count = 0, cycles = 0, seed = 32'h0000_fedf;
   always #5 mclk = ~mclk;
   vmx_regs #(.ID_VALUE(ID_V), .DEV_TYPE(DT_V)) dut_u (.mclk, .reset, .logical_addr(la), .a16_strobe, .a16_am,
      .a16_addr, .a16_write, .a16_wdata, .a16_rdata, .a16_ack, .a24_strobe, .a24_am, .a24_addr, .a24_long,
      .a24_write, .a24_wdata, .a24_rdata, .a24_ack, .coil_state, .coil_drive, .dev_reset_active);
   vmx_coil_model coil_u (.mclk, .stuck_lsb(stuck), .coil_drive, .coil_state);
   task automatic a16(input logic wr, input logic [15:0] ad, d, e, input logic ok = 1, input logic [5:0] am = AM_A16_NPRIV);
      @(negedge mclk);
      {a16_strobe, a16_write, a16_addr, a16_wdata, a16_am} <= {1'b1, wr, ad, d, am};
      if (ok) q16.push_back({!wr, 17'h0, e});
      @(negedge mclk);
      a16_strobe <= 0;
   endtask : a16
   task automatic a24(input logic wr, input logic [23:0] ad, input logic lg, input logic [31:0] d, e, input logic ok = 1);
      @(negedge mclk);
      {a24_strobe, a24_write, a24_addr, a24_long, a24_wdata, a24_am} <= {1'b1, wr, ad, lg, d, AM_A24_NPRIV};
      if (ok) q24.push_back({!wr, lg, e});
      @(negedge mclk);
      a24_strobe <= 0;
   endtask : a24
   task automatic tally_and_finish;
      `CHK("pending acks", 0, q16.size() + q24.size())
      $display("checks %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : tally_and_finish
   always @(negedge mclk) begin
      cycles++;
      if (cycles == 2000) begin
         num_errors++;
         tally_and_finish();
      end
      if (a16_ack) begin
         if (q16.size() == 0) `CHK("a16 ack", 1'b0, a16_ack)
         else begin
            t = q16.pop_front();
            if (t[33]) `CHK("a16 rdata", t[15:0], a16_rdata)
         end
      end
      if (a24_ack) begin
         if (q24.size() == 0) `CHK("a24 ack", 1'b0, a24_ack)
         else begin
            t = q24.pop_front();
            if (t[33]) `CHK("a24 rdata", t[31:0], a24_rdata)
         end
      end
   end
   initial begin
      la = 8'($random(seed));
      base = A16_WIN_BASE + {2'b00, la, 6'h00};
      repeat (8) @(negedge mclk);
      reset <= 0;
      a16(0, base, 0, ID_V);
      a16(0, base + 16'h0002, 0, DT_V);
      for (int o = 4; o < 64; o += 2) a16(0, base + 16'(o), 0, 0);
      $display("test map done");
      w = 16'($random(seed));
      a16(1, base + 16'h0006, w, 0);
      a16(0, base + 16'h0006, 0, w);
      a16(1, base + 16'h0008, w, 0);
      a16(0, base + 16'h0008, 0, 0);
      a16(1, base + 16'h0006, 16'h2000, 0);
      a16(1, base + 16'h0004, 16'h0001, 0, 0, 6'h2D);
      a16(1, base + 16'h0005, 16'h0001, 0, 0);
      a16(1, base ^ 16'h0040, 16'h0001, 0, 0);
      repeat (2) @(negedge mclk);
      `CHK("refused reset", 1'b0, dev_reset_active)
      $display("test access done");
      r = $random(seed);
      a24(1, 24'h208000, 1, r, 0);
      repeat (3) @(negedge mclk);
      `CHK("coil drive", r, coil_drive)
      a24(0, 24'h208000, 1, 0, r);
      a24(0, 24'h208002, 0, 0, {16'h0, r[31:16]});
      stuck = 1;
      repeat (2) @(negedge mclk);
      a24(0, 24'h208000, 0, 0, {16'h0, r[15:0] ^ 16'h0001});
      a16(1, base + 16'h003E, 16'h0002, 0);
      a24(0, 24'h208000, 0, 0, {16'h0, r[15:0]});
      a24(1, 24'h208002, 1, r, 0, 0);
      $display("test relay done");
      a16(0, base + 16'h0004, 0, 0);
      a16(1, base + 16'h0004, 16'h0000 | 16'h0001, 0);
      repeat (2) @(negedge mclk);
      `CHK("reset bit", 1'b1, dev_reset_active)
      `CHK("coils open", 32'h0, coil_drive)
      a16(0, base + 16'h003E, 0, 0);
      a24(1, 24'h208000, 1, r, 0);
      a16(1, base + 16'h0004, 16'h0001 & 16'hFFFE, 0);
      repeat (3) @(negedge mclk);
      `CHK("reset bit", 1'b0, dev_reset_active)
      `CHK("coils cleared", 32'h0, coil_drive)
      a24(1, 24'h208000, 1, r, 0);
      repeat (3) @(negedge mclk);
      `CHK("coils resumed", r, coil_drive)
      $display("test device reset done");
      a24(1, 24'h208000, 0, {16'h0, r[31:16]}, 0);
      a24(1, 24'h208002, 0, {16'h0, r[15:0]}, 0);
      repeat (3) @(negedge mclk);
      `CHK("coils swapped", {r[15:0], r[31:16]}, coil_drive)
      $display("test word writes done");
      tally_and_finish();
   end
endmodule : vmx_regs_tb
